//--- timer2_clock_out.sv
// 16-bit reload timer with clock output, axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
// Function
// - clock output has equal high, low phases
// - clock-out mode counts at half peripheral clock
// - overflow copies reload pair into count, or clears it in capture mode without serial selects or clock-out
// - clock-out overflows raise no interrupt request
// - output frequency is clock over 4*(65536-reload)
// - clock drives the timer pin, port bit 0
// - baud and clock-out share one reload value
// - overflow flag set only without serial selects
// - trigger fall sets external flag when enabled
// - receive select picks timer1 or own overflow
// - counter select picks clock or pin falls
// - serial selects force auto-reload on overflow
// - reload mode: overflow and trigger fall reload
// - control register resets zero, bit addressable
// - output enable makes pin a clock output when counter select is clear
module timer2_clock_out
  import timer2_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_io_pin_in,
  output logic timer_io_pin_out,
  output logic timer_io_pin_oe,
  input wire logic trigger_pin,
  input wire logic timer1_overflow,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic irq_request
);
  import timer2_pkg::*;

  logic [7:0] control_q;
  logic [1:0] mode_q;
  logic [15:0] count_q;
  logic [15:0] reload_q;
  logic half_tick_q;
  logic clk_out_q;
  logic [1:0] pin_level;
  logic [1:0] pin_fall;
  logic io_fall;
  logic trig_fall;

  pin_fall_sync #(.WIDTH(2)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({trigger_pin, timer_io_pin_in}),
    .level(pin_level),
    .fall(pin_fall)
  );
  assign io_fall = pin_fall[0];
  assign trig_fall = pin_fall[1];

  // control and mode fields
  logic ovf_flag;
  logic ext_flag;
  logic rx_sel;
  logic tx_sel;
  logic trig_en;
  logic run;
  logic cnt_sel;
  logic cap_sel;
  logic clk_out_en;
  logic updown_en;
  assign ovf_flag = control_q[OVERFLOW_FLAG_BIT];
  assign ext_flag = control_q[EXTERNAL_EVENT_FLAG_BIT];
  assign rx_sel = control_q[RX_CLOCK_SELECT_BIT];
  assign tx_sel = control_q[TX_CLOCK_SELECT_BIT];
  assign trig_en = control_q[EXTERNAL_TRIGGER_ENABLE_BIT];
  assign run = control_q[RUN_CONTROL_BIT];
  assign cnt_sel = control_q[COUNTER_SELECT_BIT];
  assign cap_sel = control_q[CAPTURE_RELOAD_SELECT_BIT];
  assign clk_out_en = mode_q[CLOCK_OUTPUT_ENABLE_BIT];
  assign updown_en = mode_q[UPDOWN_ENABLE_BIT];

  // ---------------- axi4-lite slave ----------------
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_known;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  assign wr_fire = (aw_held_q || (s_axi_awvalid && s_axi_awready))
    && (w_held_q || (s_axi_wvalid && s_axi_wready));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready && !wr_fire)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !wr_fire)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_DECERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_control;
  logic wr_set;
  logic wr_clr;
  logic wr_mode;
  logic wr_count;
  logic wr_reload;
  assign wr_control = wr_fire && wr_addr == CONTROL_ADDR && wr_strb[0];
  assign wr_set = wr_fire && wr_addr == CONTROL_SET_ADDR && wr_strb[0];
  assign wr_clr = wr_fire && wr_addr == CONTROL_CLR_ADDR && wr_strb[0];
  assign wr_mode = wr_fire && wr_addr == MODE_ADDR && wr_strb[0];
  assign wr_count = wr_fire && wr_addr == COUNT_ADDR;
  assign wr_reload = wr_fire && wr_addr == RELOAD_ADDR;
  assign wr_known = wr_addr == CONTROL_ADDR || wr_addr == CONTROL_SET_ADDR
    || wr_addr == CONTROL_CLR_ADDR || wr_addr == MODE_ADDR
    || wr_addr == COUNT_ADDR || wr_addr == RELOAD_ADDR;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        CONTROL_ADDR, CONTROL_SET_ADDR, CONTROL_CLR_ADDR:
          s_axi_rdata <= {24'h000000, control_q};
        MODE_ADDR: s_axi_rdata <= {30'h00000000, mode_q};
        COUNT_ADDR: s_axi_rdata <= {16'h0000, count_q};
        RELOAD_ADDR: s_axi_rdata <= {16'h0000, reload_q};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- timer core ----------------
  // divide-by-two enable; runs free so the rate is exact from the first tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      half_tick_q <= 1'b0;
    else
      half_tick_q <= !half_tick_q;
  end

  logic baud_mode;
  logic clkout_mode;
  logic inc_en;
  logic ovf_event;
  logic auto_reload;
  logic trig_event;
  assign baud_mode = rx_sel || tx_sel;
  assign clkout_mode = clk_out_en && !cnt_sel;
  // pin falls only count while the pin is an input
  assign inc_en = run && (cnt_sel ? (io_fall && !clk_out_en) : half_tick_q);
  assign ovf_event = inc_en && count_q == COUNT_TOP;
  assign auto_reload = !cap_sel || baud_mode || clkout_mode;
  assign trig_event = trig_en && trig_fall;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= COUNT_RESET;
    else if (wr_count)
    begin
      if (wr_strb[0])
        count_q[7:0] <= wr_data[7:0];
      if (wr_strb[1])
        count_q[15:8] <= wr_data[15:8];
    end
    else if (ovf_event)
      count_q <= auto_reload ? reload_q : COUNT_RESET;
    else if (trig_event && !cap_sel && !baud_mode)
      count_q <= reload_q;
    else if (inc_en)
      count_q <= count_q + 16'h0001;
  end

  // reload pair; capture copies the count when reload mode is off
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reload_q <= RELOAD_RESET;
    else if (wr_reload)
    begin
      if (wr_strb[0])
        reload_q[7:0] <= wr_data[7:0];
      if (wr_strb[1])
        reload_q[15:8] <= wr_data[15:8];
    end
    else if (trig_event && cap_sel && !baud_mode)
      reload_q <= count_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mode_q <= MODE_RESET;
    else if (wr_mode)
      mode_q <= wr_data[1:0];
  end

  // flags: hardware set beats a software clear in the same cycle
  logic [7:0] ctl_sw;
  logic ovf_set;
  always_comb
  begin
    ctl_sw = control_q;
    if (wr_control)
      ctl_sw = wr_data[7:0];
    if (wr_set)
      ctl_sw = control_q | wr_data[7:0];
    if (wr_clr)
      ctl_sw = control_q & ~wr_data[7:0];
  end
  assign ovf_set = ovf_event && !baud_mode && !clkout_mode;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      control_q <= CONTROL_RESET;
    else
    begin
      control_q <= ctl_sw;
      if (ovf_set)
        control_q[OVERFLOW_FLAG_BIT] <= 1'b1;
      if (trig_event)
        control_q[EXTERNAL_EVENT_FLAG_BIT] <= 1'b1;
    end
  end

  // toggling per overflow halves the rate again: clk / (4 * (65536 - reload))
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clk_out_q <= 1'b0;
    else if (clkout_mode && ovf_event)
      clk_out_q <= !clk_out_q;
  end

  assign timer_io_pin_out = clk_out_q;
  assign timer_io_pin_oe = clk_out_en;
  // own overflow also paces the serial port from the same reload value
  assign rx_baud_tick = rx_sel ? ovf_event : timer1_overflow;
  assign tx_baud_tick = tx_sel ? ovf_event : timer1_overflow;
  assign irq_request = ovf_flag || (ext_flag && !updown_en);

  // ---------------- assertions ----------------
  property p_half_rate;
    @(posedge aclk) disable iff (!aresetn)
      half_tick_q |=> !half_tick_q;
  endproperty
  a_half_rate: assert property (p_half_rate)
    else $error("count enable not at half rate");

  property p_clkout_step;
    @(posedge aclk) disable iff (!aresetn)
      clkout_mode && run && !half_tick_q && !wr_count && !trig_event |=> $stable(count_q);
  endproperty
  a_clkout_step: assert property (p_clkout_step)
    else $error("count moved off the half-rate tick");

  property p_reload;
    @(posedge aclk) disable iff (!aresetn)
      ovf_event && auto_reload && !wr_count && !wr_reload
        |=> count_q == $past(reload_q);
  endproperty
  a_reload: assert property (p_reload)
    else $error("overflow did not reload count");

  property p_no_flag_clkout;
    @(posedge aclk) disable iff (!aresetn)
      clkout_mode && ovf_event && !ovf_flag && !wr_control && !wr_set
        |=> !ovf_flag;
  endproperty
  a_no_flag_clkout: assert property (p_no_flag_clkout)
    else $error("clock-out overflow raised flag");

  property p_toggle;
    @(posedge aclk) disable iff (!aresetn)
      clkout_mode && ovf_event |=> timer_io_pin_out != $past(timer_io_pin_out);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("clock output did not toggle on overflow");

  property p_steady;
    @(posedge aclk) disable iff (!aresetn)
      !ovf_event |=> $stable(timer_io_pin_out);
  endproperty
  a_steady: assert property (p_steady)
    else $error("clock output changed without overflow");

  property p_ovf_flag;
    @(posedge aclk) disable iff (!aresetn)
      ovf_event && !baud_mode && !clkout_mode |=> ovf_flag;
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow flag not set");

  property p_ext_flag;
    @(posedge aclk) disable iff (!aresetn)
      trig_en && trig_fall |=> ext_flag;
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("external flag not set on trigger fall");

  property p_rx_sel;
    @(posedge aclk) disable iff (!aresetn)
      rx_sel && ovf_event |-> rx_baud_tick;
  endproperty
  a_rx_sel: assert property (p_rx_sel)
    else $error("receive tick missed own overflow");

  property p_tx_sel;
    @(posedge aclk) disable iff (!aresetn)
      !tx_sel |-> tx_baud_tick == timer1_overflow;
  endproperty
  a_tx_sel: assert property (p_tx_sel)
    else $error("transmit tick not from timer1");

  property p_counter_pin;
    @(posedge aclk) disable iff (!aresetn)
      run && cnt_sel && !io_fall && !trig_event && !wr_count |=> $stable(count_q);
  endproperty
  a_counter_pin: assert property (p_counter_pin)
    else $error("counter moved without pin fall");

  property p_trig_reload;
    @(posedge aclk) disable iff (!aresetn)
      trig_event && !cap_sel && !baud_mode && !ovf_event && !wr_count
        |=> count_q == $past(reload_q);
  endproperty
  a_trig_reload: assert property (p_trig_reload)
    else $error("trigger fall did not reload");

  property p_run_hold;
    @(posedge aclk) disable iff (!aresetn)
      !run && !wr_count && !trig_event |=> $stable(count_q);
  endproperty
  a_run_hold: assert property (p_run_hold)
    else $error("count moved while stopped");

  property p_reset_zero;
    @(posedge aclk) $rose(aresetn) |-> control_q == CONTROL_RESET;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("control not zero after reset");

  property p_pin_oe;
    @(posedge aclk) disable iff (!aresetn)
      wr_mode ##1 1'b1 |-> timer_io_pin_oe == $past(wr_data[CLOCK_OUTPUT_ENABLE_BIT]);
  endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("pin direction not from output enable");
endmodule // timer2_clock_out
`default_nettype wire

//--- timer2_pkg.sv
// constants shared by the clock-out timer and its register slave
package timer2_pkg;
  // register byte addresses
  localparam logic [7:0] CONTROL_ADDR = 8'hC8;
  localparam logic [7:0] MODE_ADDR = 8'hCC;
  localparam logic [7:0] COUNT_ADDR = 8'hD0;
  localparam logic [7:0] RELOAD_ADDR = 8'hD4;
  localparam logic [7:0] CONTROL_SET_ADDR = 8'hD8;
  localparam logic [7:0] CONTROL_CLR_ADDR = 8'hDC;
  // control register bit positions
  localparam int OVERFLOW_FLAG_BIT = 7;
  localparam int EXTERNAL_EVENT_FLAG_BIT = 6;
  localparam int RX_CLOCK_SELECT_BIT = 5;
  localparam int TX_CLOCK_SELECT_BIT = 4;
  localparam int EXTERNAL_TRIGGER_ENABLE_BIT = 3;
  localparam int RUN_CONTROL_BIT = 2;
  localparam int COUNTER_SELECT_BIT = 1;
  localparam int CAPTURE_RELOAD_SELECT_BIT = 0;
  // mode register bit positions
  localparam int CLOCK_OUTPUT_ENABLE_BIT = 1;
  localparam int UPDOWN_ENABLE_BIT = 0;
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  // timing: count advances once every this many peripheral clocks
  localparam int PRESCALE_DIV = 2;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

//--- pin_fall_sync.sv
// two-flop pin synchroniser with falling-edge pulse
`timescale 1ns/1ps
`default_nettype none
module pin_fall_sync #(
  parameter int WIDTH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge aclk)
      begin
        // reset high so a pin idling high gives no false edge
        if (!aresetn)
        begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
          prev_q[i] <= 1'b1;
        end
        else
        begin
          meta_q[i] <= pin_in[i];
          sync_q[i] <= meta_q[i];
          prev_q[i] <= sync_q[i];
        end
      end
      assign fall[i] = prev_q[i] & ~sync_q[i];
    end
  endgenerate

  assign level = sync_q;
endmodule // pin_fall_sync
`default_nettype wire

//--- clock_out_partner.sv
// far-side model: resolves the shared timer pin, passes the trigger, times clock phases
`timescale 1ns/1ps
`default_nettype none
module clock_out_partner
(
  input wire logic aclk,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic drive_level,
  input wire logic trigger_level,
  output logic pin_level,
  output logic trigger_pin,
  output logic [15:0] high_len,
  output logic [15:0] low_len
);
  logic [15:0] run_len;
  logic last_level;
  // outside driver only wins while the device leaves the pin as an input
  assign pin_level = pin_oe ? pin_out : drive_level;
  assign trigger_pin = trigger_level;
  initial
  begin
    run_len = 16'h0000;
    last_level = 1'b0;
    high_len = 16'h0000;
    low_len = 16'h0000;
  end
  // phase length in clocks, latched when the level flips
  always @(posedge aclk)
  begin
    if (pin_level != last_level)
    begin
      if (last_level)
        high_len <= run_len;
      else
        low_len <= run_len;
      run_len <= 16'h0001;
    end
    else
      run_len <= run_len + 16'h0001;
    last_level <= pin_level;
  end
endmodule // clock_out_partner
`default_nettype wire

//--- timer2_clock_out_test.sv
// self-checking bench for the clock-out timer and its register slave
`timescale 1ns/1ps
`default_nettype none
module timer2_clock_out_test;
  import timer2_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rv, prev;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, pin_level, trig;
  logic [1:0] bresp, rresp, rr;
  logic [1:0] wresp = 2'h0;
  logic drive_level = 1'b1, trigger_level = 1'b1, t1_ovf = 1'b0, rx_tick, tx_tick, irq;
  logic [15:0] high_len, low_len;
  int fail_count = 0;
  int n_compared = 0;
  int k;
  always #4 aclk = ~aclk;
  timer2_clock_out dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timer_io_pin_in(pin_level), .timer_io_pin_out(pin_out), .timer_io_pin_oe(pin_oe),
    .trigger_pin(trig), .timer1_overflow(t1_ovf), .rx_baud_tick(rx_tick),
    .tx_baud_tick(tx_tick), .irq_request(irq));
  clock_out_partner far (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .drive_level(drive_level), .trigger_level(trigger_level), .pin_level(pin_level),
    .trigger_pin(trig), .high_len(high_len), .low_len(low_len));
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // readies sampled mid-cycle, where they are settled, and acted on at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic aw_t, w_t, b_t;
    n = 0;
    b_t = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t)
    begin
      @(negedge aclk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid & bready;
      if (b_t)
        wresp = bresp;
      @(posedge aclk);
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
      if (b_t)
        bready <= 1'b0;
      n++;
      if (n > 100)
      begin
        fail_count++;
        final_report();
      end
    end
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ar_t, r_t;
    n = 0;
    r_t = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t)
    begin
      @(negedge aclk);
      ar_t = arvalid & arready;
      r_t = rvalid & rready;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ar_t)
        arvalid <= 1'b0;
      if (r_t)
        rready <= 1'b0;
      n++;
      if (n > 100)
      begin
        fail_count++;
        final_report();
      end
    end
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(CONTROL_ADDR, rv, rr);
    check(rv, {24'h0, CONTROL_RESET});
    check({31'h0, pin_oe}, 32'h0);
    rd_reg(8'hE0, rv, rr);
    check({30'h0, rr}, {30'h0, RESP_DECERR});
    check(rv, 32'h0);
    // unmapped write must answer an error and leave control alone
    wr(8'hE0, 32'hFF, 4'h1);
    check({30'h0, wresp}, {30'h0, RESP_DECERR});
    wr(CONTROL_SET_ADDR, 32'h08, 4'h1);
    check({30'h0, wresp}, {30'h0, RESP_OKAY});
    rd_reg(CONTROL_ADDR, rv, rr);
    check(rv, 32'h08);
    wr(CONTROL_CLR_ADDR, 32'h08, 4'h1);
    rd_reg(CONTROL_ADDR, rv, rr);
    check(rv, 32'h00);
    // clock-out set-up order, transmit baud from own overflow as well
    wr(MODE_ADDR, 32'h2, 4'h1);
    wr(CONTROL_ADDR, 32'h10, 4'h1);
    wr(RELOAD_ADDR, 32'hFFFC, 4'h3);
    wr(COUNT_ADDR, 32'hFFFC, 4'h3);
    wr(CONTROL_SET_ADDR, 32'h04, 4'h1);
    repeat (60) @(posedge aclk);
    @(negedge aclk);
    check({31'h0, pin_oe}, 32'h1);
    check({16'h0, high_len}, 32'd8);
    check({16'h0, low_len}, 32'd8);
    check({31'h0, irq}, 32'h0);
    k = 0;
    repeat (80)
    begin
      @(negedge aclk);
      if (tx_tick === 1'b1)
        k++;
    end
    check(k, 10);
    rd_reg(CONTROL_ADDR, rv, rr);
    check(rv, 32'h14);
    wr(CONTROL_CLR_ADDR, 32'h04, 4'h1);
    rd_reg(COUNT_ADDR, prev, rr);
    repeat (10) @(posedge aclk);
    rd_reg(COUNT_ADDR, rv, rr);
    check(rv, prev);
    // about 43 clocks of run time; only a half-rate count lands in this band
    wr(COUNT_ADDR, 32'h0, 4'h3);
    wr(CONTROL_SET_ADDR, 32'h04, 4'h1);
    repeat (40) @(posedge aclk);
    wr(CONTROL_CLR_ADDR, 32'h04, 4'h1);
    rd_reg(COUNT_ADDR, rv, rr);
    check((rv >= 19 && rv <= 24) ? 32'h1 : 32'h0, 32'h1);
    wr(MODE_ADDR, 32'h0, 4'h1);
    wr(RELOAD_ADDR, 32'h1234, 4'h3);
    wr(COUNT_ADDR, 32'hFFF0, 4'h3);
    wr(CONTROL_ADDR, 32'h04, 4'h1);
    repeat (60) @(posedge aclk);
    wr(CONTROL_CLR_ADDR, 32'h04, 4'h1);
    rd_reg(COUNT_ADDR, rv, rr);
    check(rv & 32'hFF00, 32'h1200);
    rd_reg(CONTROL_ADDR, rv, rr);
    check(rv, 32'h80);
    @(negedge aclk);
    check({31'h0, irq}, 32'h1);
    wr(CONTROL_CLR_ADDR, 32'h80, 4'h1);
    rd_reg(CONTROL_ADDR, rv, rr);
    check(rv, 32'h00);
    // capture selected, yet the receive select must force reload and mute the flag
    wr(CONTROL_ADDR, 32'h21, 4'h1);
    wr(COUNT_ADDR, 32'hFFF0, 4'h3);
    wr(CONTROL_SET_ADDR, 32'h04, 4'h1);
    repeat (60) @(posedge aclk);
    wr(CONTROL_CLR_ADDR, 32'h04, 4'h1);
    rd_reg(COUNT_ADDR, rv, rr);
    check(rv & 32'hFF00, 32'h1200);
    rd_reg(CONTROL_ADDR, rv, rr);
    check(rv, 32'h21);
    @(posedge aclk);
    t1_ovf <= 1'b1;
    @(negedge aclk);
    check({31'h0, tx_tick}, 32'h1);
    check({31'h0, rx_tick}, 32'h0);
    @(posedge aclk);
    t1_ovf <= 1'b0;
    wr(CONTROL_ADDR, 32'h08, 4'h1);
    wr(COUNT_ADDR, 32'h5555, 4'h3);
    @(posedge aclk);
    trigger_level <= 1'b0;
    repeat (8) @(posedge aclk);
    trigger_level <= 1'b1;
    rd_reg(CONTROL_ADDR, rv, rr);
    check(rv, 32'h48);
    rd_reg(COUNT_ADDR, rv, rr);
    check(rv, 32'h1234);
    @(negedge aclk);
    check({31'h0, irq}, 32'h1);
    wr(MODE_ADDR, 32'h1, 4'h1);
    @(negedge aclk);
    check({31'h0, irq}, 32'h0);
    wr(CONTROL_CLR_ADDR, 32'h40, 4'h1);
    rd_reg(CONTROL_ADDR, rv, rr);
    check(rv, 32'h08);
    wr(MODE_ADDR, 32'h0, 4'h1);
    wr(COUNT_ADDR, 32'h0, 4'h3);
    wr(CONTROL_ADDR, 32'h06, 4'h1);
    repeat (3)
    begin
      repeat (6) @(posedge aclk);
      drive_level <= 1'b0;
      repeat (6) @(posedge aclk);
      drive_level <= 1'b1;
    end
    repeat (6) @(posedge aclk);
    rd_reg(COUNT_ADDR, rv, rr);
    check(rv, 32'h3);
    final_report();
  end
endmodule // timer2_clock_out_test
`default_nettype wire
